// ### clk_mode_pkg.sv
/*
 Package for the dual clock power mode controller: register offsets, field
 positions, reset values, mode encoding and timing constants.
 Assumes a single 40 MHz ref_clk domain and a plain register port.
*/
package clk_mode_pkg;

    localparam logic [7:0] INTR_EN_OFFSET = 8'h0b;
    localparam logic [7:0] CLK_CTRL_OFFSET = 8'h0f;
    localparam logic [7:0] MODE_STAT_OFFSET = 8'h10;

    localparam logic [7:0] INTR_EN_RESET = 8'h00;
    localparam logic [7:0] CLK_CTRL_RESET = 8'h0b;

    localparam int WAKE_TIMER_EN_BIT = 3;
    localparam int TIMER_TWO_IE_BIT = 6;
    localparam int SLOW_TYPE_BIT = 7;
    localparam int FAST_TYPE_BIT = 6;
    localparam int SLOW_HALT_BIT = 4;
    localparam int FAST_HALT_BIT = 3;
    localparam int CLK_SEL_BIT = 2;
    localparam int DIV_LSB = 0;
    localparam logic [7:0] CLK_CTRL_MASK = 8'hdf;

    localparam logic [1:0] WDOG_ALWAYS_ON = 2'h3;

    localparam logic [1:0] DIV_BY_8 = 2'h0;
    localparam logic [1:0] DIV_BY_4 = 2'h1;
    localparam logic [1:0] DIV_BY_2 = 2'h2;
    localparam logic [1:0] DIV_BY_1 = 2'h3;

    localparam int FAST_RC_MHZ = 16;
    localparam int REF_CLK_MHZ = 40;

    typedef enum logic [1:0] {
        MODE_SLOW = 2'b00,
        MODE_FAST = 2'b01,
        MODE_IDLE = 2'b10,
        MODE_STOP = 2'b11
    } power_mode_e;

    typedef struct packed {
        logic ext_pin;
        logic wake_timer;
        logic timer_two;
    } wake_src_s;

    typedef struct packed {
        logic fast_osc_run;
        logic slow_osc_run;
        logic fast_is_crystal;
        logic slow_is_crystal;
        logic sys_clk_run;
        logic sys_from_fast;
        logic wake_timer_run;
        logic timer_two_run;
    } osc_ctrl_s;

endpackage

// ### clk_divider.sv
/*
 Programmable enable divider for the system clock source.
 Assumes src_en pulses one cycle per source clock tick in the ref_clk domain.
*/
`timescale 1ns/1ps
module clk_divider
    import clk_mode_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic src_en,
    input wire logic [1:0] div_sel,
    output logic tick
);

    logic [2:0] count_reg;
    logic [2:0] limit;

    // Terminal count per divider code
    always_comb begin
        case (div_sel)
            DIV_BY_8: limit = 3'h7;
            DIV_BY_4: limit = 3'h3;
            DIV_BY_2: limit = 3'h1;
            DIV_BY_1: limit = 3'h0;
            default: limit = 3'h0;
        endcase
    end

    // Counter restarts if the code shrinks below the count
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count_reg <= 3'h0;
        end else if (src_en) begin
            if (count_reg >= limit) begin
                count_reg <= 3'h0;
            end else begin
                count_reg <= count_reg + 3'h1;
            end
        end
    end

    // Handshake-style pulse may be combinational
    assign tick = src_en && (count_reg >= limit);

endmodule

// ### clk_mode_ctrl.sv
/*
 Clock and power mode controller: register port, mode state machine,
 oscillator gating, wake-up filtering and system clock enable.
 Assumes oscillator ticks arrive as one-cycle enables on ref_clk; the
 external wake pin is asynchronous and is synchronised here.
*/
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module clk_mode_ctrl
    import clk_mode_pkg::*;
#(
    parameter int SYNC_STAGES = 3
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sleep_exec,
    input wire logic [1:0] watchdog_enable_field,
    input wire logic timer2_clk_select,
    input wire logic ext_wake_pin,
    input wire logic wake_timer_irq,
    input wire logic timer_two_irq,
    input wire logic fast_src_tick,
    input wire logic slow_src_tick,
    output logic sys_clk_en,
    output osc_ctrl_s osc_ctrl,
    output power_mode_e power_mode,
    output logic [7:0] interrupt_enable_bits
);

    // Filter needs a settling stage plus two agreeing stages
    if (SYNC_STAGES < 3) begin : g_stage_check
        $error("SYNC_STAGES must be at least 3");
    end

    logic [7:0] intr_en_reg;
    logic [7:0] intr_en_next;
    logic [7:0] clk_ctrl_reg;
    logic [7:0] clk_ctrl_next;
    power_mode_e mode_reg;
    power_mode_e mode_next;
    logic [7:0] rdata_reg;
    logic [SYNC_STAGES-1:0] pin_sync_reg;
    logic pin_agree;
    logic pin_level_reg;
    logic pin_rise;
    wake_src_s wake;
    logic wake_any;
    logic src_tick;
    logic div_tick;
    osc_ctrl_s osc_next;

    // Field views of the clock control register
    logic slow_type;
    logic fast_type;
    logic slow_halt;
    logic fast_halt;
    logic clk_sel;
    logic [1:0] div_sel;
    // Type views follow the value about to be stored; the halt, select and divider views follow the stored value
    assign slow_type = clk_ctrl_next[SLOW_TYPE_BIT];
    assign fast_type = clk_ctrl_next[FAST_TYPE_BIT];
    assign slow_halt = clk_ctrl_reg[SLOW_HALT_BIT];
    assign fast_halt = clk_ctrl_reg[FAST_HALT_BIT];
    assign clk_sel = clk_ctrl_reg[CLK_SEL_BIT];
    assign div_sel = clk_ctrl_reg[DIV_LSB+1:DIV_LSB];

    // Apply a write to the clock control register with hardware guards
    function automatic logic [7:0] guard_clk_write(input logic [7:0] cur,
                                                   input logic [7:0] wr);
        logic [7:0] res;
        res = wr & CLK_CTRL_MASK;
        // Source type may only move while the other clock drives the core
        if (!cur[CLK_SEL_BIT]) begin
            res[SLOW_TYPE_BIT] = cur[SLOW_TYPE_BIT];
        end
        if (cur[CLK_SEL_BIT]) begin
            res[FAST_TYPE_BIT] = cur[FAST_TYPE_BIT];
        end
        // Never both halted fast clock and fast clock selected
        if (res[FAST_HALT_BIT] && res[CLK_SEL_BIT]) begin
            res = cur;
        end
        return res;
    endfunction

    // Something still needs the slow source after sleep: idle rather than stop
    function automatic logic slow_kept_alive(input logic halt_on_sleep,
                                             input logic wake_timer_on,
                                             input logic [1:0] wdog);
        logic keep;
        keep = !halt_on_sleep || wake_timer_on;
        if (wdog == WDOG_ALWAYS_ON) begin
            keep = 1'b1;
        end
        return keep;
    endfunction

    // Register writes; the clock control write is filtered, and refused whole if it both halts and selects the fast clock
    always_comb begin
        clk_ctrl_next = clk_ctrl_reg;
        if (reg_wr && reg_addr == CLK_CTRL_OFFSET) begin
            clk_ctrl_next = guard_clk_write(clk_ctrl_reg, reg_wdata);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            clk_ctrl_reg <= CLK_CTRL_RESET;
        end else begin
            clk_ctrl_reg <= clk_ctrl_next;
        end
    end

    // Next enable value; the oscillator table must see a write at once
    always_comb begin
        intr_en_next = intr_en_reg;
        if (reg_wr && reg_addr == INTR_EN_OFFSET) begin
            intr_en_next = reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            intr_en_reg <= INTR_EN_RESET;
        end else begin
            intr_en_reg <= intr_en_next;
        end
    end

    // Read data one cycle after the strobe, zero otherwise and when unmapped
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                INTR_EN_OFFSET: rdata_reg <= intr_en_reg;
                CLK_CTRL_OFFSET: rdata_reg <= clk_ctrl_reg;
                MODE_STAT_OFFSET: rdata_reg <= {6'h00, mode_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end
    assign reg_rdata = rdata_reg;
    assign interrupt_enable_bits = intr_en_reg;

    // External wake pin: three stages, change counts when last two agree
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_sync_reg <= {SYNC_STAGES{1'b0}};
        end else begin
            pin_sync_reg <= {pin_sync_reg[SYNC_STAGES-2:0], ext_wake_pin};
        end
    end

    // Only the last two stages vote; the first may still be settling
    assign pin_agree = pin_sync_reg[SYNC_STAGES-2] == pin_sync_reg[SYNC_STAGES-1];

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_level_reg <= 1'b0;
        end else if (pin_agree) begin
            pin_level_reg <= pin_sync_reg[SYNC_STAGES-1];
        end
    end
    assign pin_rise = pin_agree && pin_sync_reg[SYNC_STAGES-1] && !pin_level_reg;

    // Wake sources qualified per sleep state
    always_comb begin
        wake.ext_pin = pin_rise;
        // Wake timer only counts and interrupts when enabled
        wake.wake_timer = wake_timer_irq && intr_en_reg[WAKE_TIMER_EN_BIT];
        wake.timer_two = timer_two_irq && intr_en_reg[TIMER_TWO_IE_BIT];
        case (mode_reg)
            MODE_IDLE: wake_any = wake.ext_pin || wake.wake_timer ||
                                  wake.timer_two;
            MODE_STOP: wake_any = wake.ext_pin;
            default: wake_any = 1'b0;
        endcase
    end

    // Mode state machine; sleep picks idle or stop from the keep-alive terms
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_SLOW, MODE_FAST: begin
                if (sleep_exec) begin
                    // Any live slow source keeps us in idle rather than stop
                    if (slow_kept_alive(slow_halt, intr_en_reg[WAKE_TIMER_EN_BIT],
                                        watchdog_enable_field)) begin
                        mode_next = MODE_IDLE;
                    end else begin
                        mode_next = MODE_STOP;
                    end
                end else if (clk_ctrl_next[CLK_SEL_BIT]) begin
                    mode_next = MODE_FAST;
                end else begin
                    mode_next = MODE_SLOW;
                end
            end
            MODE_IDLE, MODE_STOP: begin
                // Resume whichever clock was selected before sleep
                if (wake_any) begin
                    mode_next = clk_sel ? MODE_FAST : MODE_SLOW;
                end
            end
            default: mode_next = MODE_SLOW;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_reg <= MODE_SLOW;
        end else begin
            mode_reg <= mode_next;
        end
    end
    assign power_mode = mode_reg;

    // Oscillator controls follow the mode table
    always_comb begin
        osc_next.fast_is_crystal = fast_type;
        osc_next.slow_is_crystal = slow_type;
        osc_next.sys_from_fast = clk_ctrl_next[CLK_SEL_BIT];
        case (mode_next)
            MODE_FAST: begin
                osc_next.fast_osc_run = 1'b1;
                osc_next.slow_osc_run = 1'b1;
                osc_next.sys_clk_run = 1'b1;
                osc_next.wake_timer_run = intr_en_next[WAKE_TIMER_EN_BIT];
                osc_next.timer_two_run = 1'b1;
            end
            MODE_SLOW: begin
                osc_next.fast_osc_run = !clk_ctrl_next[FAST_HALT_BIT];
                osc_next.slow_osc_run = 1'b1;
                osc_next.sys_clk_run = 1'b1;
                osc_next.wake_timer_run = intr_en_next[WAKE_TIMER_EN_BIT];
                osc_next.timer_two_run = 1'b1;
            end
            MODE_IDLE: begin
                osc_next.fast_osc_run = 1'b0;
                // Same keep-alive terms that chose idle over stop
                osc_next.slow_osc_run = slow_kept_alive(slow_halt,
                                                        intr_en_reg[WAKE_TIMER_EN_BIT],
                                                        watchdog_enable_field);
                osc_next.sys_clk_run = 1'b0;
                osc_next.wake_timer_run = intr_en_next[WAKE_TIMER_EN_BIT];
                osc_next.timer_two_run = !slow_halt && !timer2_clk_select;
            end
            MODE_STOP: begin
                // Everything halted; no clock produced at all
                osc_next.fast_osc_run = 1'b0;
                osc_next.slow_osc_run = 1'b0;
                osc_next.sys_clk_run = 1'b0;
                osc_next.wake_timer_run = 1'b0;
                osc_next.timer_two_run = 1'b0;
            end
            default: begin
                osc_next.fast_osc_run = 1'b0;
                osc_next.slow_osc_run = 1'b1;
                osc_next.sys_clk_run = 1'b1;
                osc_next.wake_timer_run = 1'b0;
                osc_next.timer_two_run = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            osc_ctrl <= '{fast_osc_run: 1'b0, slow_osc_run: 1'b1,
                          fast_is_crystal: 1'b0, slow_is_crystal: 1'b0,
                          sys_clk_run: 1'b1, sys_from_fast: 1'b0,
                          wake_timer_run: 1'b0, timer_two_run: 1'b1};
        end else begin
            osc_ctrl <= osc_next;
        end
    end

    // Source tick chosen by clock select; fast tick nominally 16 MHz rate
    assign src_tick = clk_sel ? fast_src_tick : slow_src_tick;

    clk_divider u_div (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .src_en(src_tick),
        .div_sel(div_sel),
        .tick(div_tick)
    );

    // No system clock enable while sleeping
    assign sys_clk_en = div_tick && osc_ctrl.sys_clk_run;

endmodule

// ### clk_mode_props.sv
/*
 Checker for the clock mode controller, watching top ports only.
 Assumes one ref_clk domain and a bind from the testbench top file.
*/
`timescale 1ns/1ps
module clk_mode_props
    import clk_mode_pkg::*;
#(
    parameter int SYNC_STAGES = 3
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic sleep_exec,
    input wire logic [1:0] watchdog_enable_field,
    input wire logic timer2_clk_select,
    input wire logic ext_wake_pin,
    input wire logic wake_timer_irq,
    input wire logic timer_two_irq,
    input wire logic fast_src_tick,
    input wire logic slow_src_tick,
    input wire logic sys_clk_en,
    input wire osc_ctrl_s osc_ctrl,
    input wire power_mode_e power_mode,
    input wire logic [7:0] interrupt_enable_bits
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Running modes and clock control writes
    wire run = power_mode inside {MODE_SLOW, MODE_FAST};
    wire ctl_wr = reg_wr && reg_addr == CLK_CTRL_OFFSET && run && !sleep_exec;
    wire bad_wr = reg_wdata[FAST_HALT_BIT] && reg_wdata[CLK_SEL_BIT];
    // Sleep and wake steps
    sequence idle_sleep;
        run && sleep_exec && (watchdog_enable_field == WDOG_ALWAYS_ON ||
            interrupt_enable_bits[WAKE_TIMER_EN_BIT]);
    endsequence
    sequence timer_wake;
        power_mode == MODE_IDLE && ((wake_timer_irq && interrupt_enable_bits[3]) ||
            (timer_two_irq && interrupt_enable_bits[6]));
    endsequence
    sel_follows_a: assert property (ctl_wr && !bad_wr |=> power_mode ==
        ($past(reg_wdata[CLK_SEL_BIT]) ? MODE_FAST : MODE_SLOW)) else $error("mode not selected");
    halt_follows_a: assert property (ctl_wr && !bad_wr |=>
        osc_ctrl.fast_osc_run == !$past(reg_wdata[FAST_HALT_BIT])) else $error("fast halt lost");
    blocked_wr_a: assert property (ctl_wr && bad_wr |=>
        $stable(osc_ctrl) && $stable(power_mode)) else $error("bad write taken");
    idle_entry_a: assert property (idle_sleep |=> power_mode == MODE_IDLE)
        else $error("stop entered");
    idle_clocks_a: assert property (power_mode == MODE_IDLE |-> !sys_clk_en &&
        !osc_ctrl.fast_osc_run && osc_ctrl.slow_osc_run) else $error("idle clocks");
    stop_clocks_a: assert property (power_mode == MODE_STOP |-> !sys_clk_en &&
        osc_ctrl[7:6] == 2'h0 && osc_ctrl[1:0] == 2'h0) else $error("stop clocks");
    timer_wake_a: assert property (timer_wake |=> run) else $error("no timer wake");
    stop_hold_a: assert property ((power_mode == MODE_STOP && !ext_wake_pin)[*6]
        |=> power_mode == MODE_STOP) else $error("stop left");
    pin_wake_a: assert property (power_mode != MODE_SLOW && !run &&
        $rose(ext_wake_pin) |-> ##[1:8] run) else $error("no pin wake");
endmodule

// ### osc_model.sv
/*
 Oscillator model: one-cycle tick enables of the fast and slow sources.
 Assumes osc_ctrl from the controller on the same ref_clk.
*/
`timescale 1ns/1ps
module osc_model
    import clk_mode_pkg::*;
#(
    parameter int FAST_XTAL_MHZ = 8,
    parameter int SLOW_DIV = 5
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire osc_ctrl_s osc_ctrl,
    output logic fast_src_tick,
    output logic slow_src_tick
);
    int fast_acc;
    int slow_cnt;
    int rate;
    // Crystal rate is arbitrary; RC is the nominal one
    assign rate = osc_ctrl.fast_is_crystal ? FAST_XTAL_MHZ : FAST_RC_MHZ;
    // Fast source ticks by phase accumulation, silent while halted
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !osc_ctrl.fast_osc_run) begin
            fast_acc <= 0;
            fast_src_tick <= 1'b0;
        end else begin
            fast_src_tick <= fast_acc + rate >= REF_CLK_MHZ;
            fast_acc <= (fast_acc + rate) % REF_CLK_MHZ;
        end
    end
    // Slow source, held still when halted by sleep
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !osc_ctrl.slow_osc_run) begin
            slow_cnt <= 0;
            slow_src_tick <= 1'b0;
        end else begin
            slow_src_tick <= slow_cnt == SLOW_DIV - 1;
            slow_cnt <= (slow_cnt + 1) % SLOW_DIV;
        end
    end
endmodule

// ### tb_top.sv
/*
 Testbench for the clock mode controller with oscillator model.
 Assumes 40 MHz ref_clk and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module tb_top
    import clk_mode_pkg::*;
;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sleep_exec = 1'b0;
    logic [1:0] watchdog_enable_field = 2'h0;
    logic timer2_clk_select = 1'b0;
    logic ext_wake_pin = 1'b0;
    logic wake_timer_irq = 1'b0;
    logic timer_two_irq = 1'b0;
    logic fast_src_tick, slow_src_tick, sys_clk_en;
    logic [7:0] reg_rdata, interrupt_enable_bits, v, ctl;
    osc_ctrl_s osc_ctrl;
    power_mode_e power_mode;
    int fails = 0;
    int n_tests = 0;
    int seed = 37;
    int ne, ns, r;
    int divs[4] = '{8, 4, 2, 1};
    logic [7:0] steps[7] = '{8'h83, 8'h47, 8'hc7, 8'h0f, 8'h83, 8'h8b, 8'h0b};
    // Free-running 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;
    clk_mode_ctrl DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_exec(sleep_exec), .watchdog_enable_field(watchdog_enable_field),
        .timer2_clk_select(timer2_clk_select), .ext_wake_pin(ext_wake_pin),
        .wake_timer_irq(wake_timer_irq), .timer_two_irq(timer_two_irq),
        .fast_src_tick(fast_src_tick), .slow_src_tick(slow_src_tick), .sys_clk_en(sys_clk_en),
        .osc_ctrl(osc_ctrl), .power_mode(power_mode),
        .interrupt_enable_bits(interrupt_enable_bits));
    osc_model osc (.ref_clk(ref_clk), .sys_rst(sys_rst), .osc_ctrl(osc_ctrl),
        .fast_src_tick(fast_src_tick), .slow_src_tick(slow_src_tick));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // Expected clock control after a write
    function automatic logic [7:0] ctl_next(input logic [7:0] c, input logic [7:0] w);
        logic [7:0] n;
        n = w & CLK_CTRL_MASK;
        if (w[FAST_HALT_BIT] && w[CLK_SEL_BIT]) return c;
        if (!c[CLK_SEL_BIT]) n[SLOW_TYPE_BIT] = c[SLOW_TYPE_BIT];
        else n[FAST_TYPE_BIT] = c[FAST_TYPE_BIT];
        return n;
    endfunction
    task automatic wr_ctl(input logic [7:0] d);
        logic [7:0] q;
        wr(CLK_CTRL_OFFSET, d);
        ctl = ctl_next(ctl, d);
        check(power_mode, ctl[2] ? MODE_FAST : MODE_SLOW);
        check({osc_ctrl[7], osc_ctrl[5:4], osc_ctrl[2]}, {!ctl[3], ctl[6], ctl[7], ctl[2]});
        rd(CLK_CTRL_OFFSET, q);
        check(q, ctl);
    endtask
    task automatic sleep_now();
        @(posedge ref_clk);
        sleep_exec <= 1'b1;
        @(posedge ref_clk);
        sleep_exec <= 1'b0;
        #1;
    endtask
    // One wake source held for 8 cycles, enough for the pin synchroniser
    task automatic wake(input int s);
        @(posedge ref_clk);
        wake_timer_irq <= (s == 0);
        timer_two_irq <= (s == 1);
        ext_wake_pin <= (s == 2);
        repeat (8) @(posedge ref_clk);
        {wake_timer_irq, timer_two_irq, ext_wake_pin} <= 3'b000;
        #1;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        report_and_stop();
    end
    initial begin
        ctl = CLK_CTRL_RESET;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(CLK_CTRL_OFFSET, v);
        check(v, 8'h0b);
        rd(INTR_EN_OFFSET, v);
        check(v, 8'h00);
        check(osc_ctrl, 8'h49);
        rd(8'h20, v);
        check(v, 8'h00);
        $display("reset test done");
        // Ordered mode changes, type bits, blocked writes, then random ones
        foreach (steps[k]) wr_ctl(steps[k]);
        repeat (40) begin
            r = $random(seed);
            timer2_clk_select <= r[9];
            wr_ctl(r[7:0]);
        end
        $display("register test done");
        for (int k = 0; k < 4; k++) begin
            wr_ctl(8'h08 | k[7:0]);
            ne = 0;
            ns = 0;
            repeat (200) begin
                @(posedge ref_clk);
                #1;
                ne += sys_clk_en;
                ns += slow_src_tick;
            end
            check(ns / divs[k] - ne inside {-1, 0, 1}, 1'b1);
        end
        $display("divider test done");
        wr_ctl(8'h03);
        wr_ctl(8'h07);
        timer2_clk_select <= 1'b0;
        for (int s = 0; s < 3; s++) begin
            wr(INTR_EN_OFFSET, s == 0 ? 8'h08 : s == 1 ? 8'h40 : 8'h00);
            check(interrupt_enable_bits, s == 0 ? 8'h08 : s == 1 ? 8'h40 : 8'h00);
            check(osc_ctrl.wake_timer_run, s == 0);
            sleep_now();
            check(power_mode, MODE_IDLE);
            wake(s);
            check(power_mode, MODE_FAST);
        end
        $display("idle test done");
        wr_ctl(8'h03);
        wr_ctl(8'h1b);
        wr(INTR_EN_OFFSET, 8'h00);
        for (int w = 0; w < 2; w++) begin
            watchdog_enable_field <= w ? WDOG_ALWAYS_ON : 2'h2;
            sleep_now();
            check(power_mode, w ? MODE_IDLE : MODE_STOP);
            rd(MODE_STAT_OFFSET, v);
            check(v, {6'h00, w ? MODE_IDLE : MODE_STOP});
            wake(0);
            wake(1);
            check(power_mode, w ? MODE_IDLE : MODE_STOP);
            wake(2);
            check(power_mode, MODE_SLOW);
        end
        $display("stop test done");
        report_and_stop();
    end
endmodule
bind clk_mode_ctrl clk_mode_props #(.SYNC_STAGES(SYNC_STAGES)) props_i (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_exec(sleep_exec),
    .watchdog_enable_field(watchdog_enable_field), .timer2_clk_select(timer2_clk_select),
    .ext_wake_pin(ext_wake_pin), .wake_timer_irq(wake_timer_irq),
    .timer_two_irq(timer_two_irq), .fast_src_tick(fast_src_tick),
    .slow_src_tick(slow_src_tick), .sys_clk_en(sys_clk_en), .osc_ctrl(osc_ctrl),
    .power_mode(power_mode), .interrupt_enable_bits(interrupt_enable_bits));
